// ==== inc/trecv_pkg.sv ====
// Purpose: Shared constants for the terminal receive-end and interlock block
// Assumes: 10 MHz clock, one clock domain
// Notes:   Times are given in their own unit with derived cycle counts
package trecv_pkg;
	localparam int unsigned CLK_HZ            = 10000000;
	localparam int unsigned TIMEOUT_MS        = 1000;
	localparam int unsigned TIMEOUT_CYCLES    = (CLK_HZ / 1000) * TIMEOUT_MS;
	localparam int unsigned TIMER_W           = 24;
	localparam int unsigned CHAR_W            = 7;
	localparam logic [6:0]  EOT_CODE_DEFAULT  = 7'h1f;
	localparam logic [6:0]  BUF_RESET_VALUE   = 7'h00;
	localparam logic        MODE_A_RESET      = 1'b1;
	localparam logic        MODE_B_RESET      = 1'b1;
	localparam logic [2:0]  SYNC_RESET        = 3'h0;
endpackage : trecv_pkg

// ==== verilog/trecv_sync.sv ====
// Purpose: Three-stage synchroniser for pin inputs
// Assumes: Input is asynchronous to clk
// Notes:   Change accepted once stages two and three agree
`timescale 1ns/1ps
`default_nettype none
module trecv_sync (
	input  wire logic clk,
	input  wire logic sys_rst,
	input  wire logic din,
	output var  logic dout
);
	logic [2:0] stage;

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			stage <= trecv_pkg::SYNC_RESET;
		end else begin
			stage <= {stage[1:0], din};
		end
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			dout <= 1'b0;
		end else if (stage[1] == stage[2]) begin
			dout <= stage[2];
		end
	end
endmodule : trecv_sync
`default_nettype wire

// ==== verilog/trecv_ctrl.sv ====
// Purpose: Receive-end, overflow reset, power-on reset, motor, keyboard lock, lowercase
// Assumes: Same-clock strobes from serdes logic; pins pass through trecv_sync
// Notes:   Mode triggers A and B both set means control-receive
`timescale 1ns/1ps
`default_nettype none
module trecv_ctrl #(
	parameter logic [6:0]  EOT_CODE       = trecv_pkg::EOT_CODE_DEFAULT,
	parameter int unsigned TIMEOUT_CYCLES = trecv_pkg::TIMEOUT_CYCLES
) (
	input  wire logic       clk,
	input  wire logic       sys_rst,
	input  wire logic       dc_power_ok,
	input  wire logic       supply_relay,
	input  wire logic       modem_ready,
	input  wire logic       carrier_detect,
	input  wire logic       dialup_fitted,
	input  wire logic       communicate,
	input  wire logic       clear_to_send,
	input  wire logic       uppercase_contact,
	input  wire logic       io_cycle,
	input  wire logic       long_function,
	input  wire logic       end_of_state_latch,
	input  wire logic       op_busy,
	input  wire logic       control_clock,
	input  wire logic       first_buf_load,
	input  wire logic [6:0] first_buf_data,
	input  wire logic       second_buf_load,
	input  wire logic       shift_stage_one,
	input  wire logic       serdes_delay_one,
	input  wire logic       control_char_load,
	input  wire logic [6:0] control_char,
	input  wire logic       set_mode_a_off,
	input  wire logic       set_mode_b_off,
	output var  logic       power_on_reset,
	output var  logic       mode_change,
	output var  logic       mode_a,
	output var  logic       mode_b,
	output var  logic [6:0] first_char_buffer,
	output var  logic       first_full,
	output var  logic [6:0] second_char_buffer,
	output var  logic       second_full,
	output var  logic       overflow_reset,
	output var  logic       second_reset,
	output var  logic       second_reset_gate,
	output var  logic       motor_run,
	output var  logic       keyboard_lock,
	output var  logic       time_out_latch,
	output var  logic       initial_lowercase,
	output var  logic       shift_trip_drive,
	output var  logic       shift_magnet_drive
);
	logic dc_s, relay_s, ready_s, carrier_s, comm_s, cts_s, uc_s;
	logic eot_hold;
	logic lock_eot;
	logic [trecv_pkg::TIMER_W-1:0] timer;
	logic timer_run;
	// Counter width for the one-second time-out
	localparam int unsigned TIMER_W = trecv_pkg::TIMER_W;

	// Pin synchronisers
	trecv_sync u_dc (.clk(clk), .sys_rst(sys_rst), .din(dc_power_ok), .dout(dc_s));
	trecv_sync u_rl (.clk(clk), .sys_rst(sys_rst), .din(supply_relay), .dout(relay_s));
	trecv_sync u_rd (.clk(clk), .sys_rst(sys_rst), .din(modem_ready), .dout(ready_s));
	trecv_sync u_cd (.clk(clk), .sys_rst(sys_rst), .din(carrier_detect), .dout(carrier_s));
	trecv_sync u_cm (.clk(clk), .sys_rst(sys_rst), .din(communicate), .dout(comm_s));
	trecv_sync u_ct (.clk(clk), .sys_rst(sys_rst), .din(clear_to_send), .dout(cts_s));
	trecv_sync u_uc (.clk(clk), .sys_rst(sys_rst), .din(uppercase_contact), .dout(uc_s));

	// Mode decode
	function automatic logic is_ctrl_recv(input logic a, input logic b);
		is_ctrl_recv = a & b;
	endfunction : is_ctrl_recv

	wire logic ctrl_recv   = is_ctrl_recv(mode_a, mode_b);
	// Transmit mode: trigger A on, trigger B off
	wire logic sending     = mode_a & ~mode_b;
	wire logic line_lost   = ~ready_s | (dialup_fitted & ~carrier_s);
	wire logic por_cond    = (dc_s & ~relay_s) | line_lost;
	wire logic eot_in_buf  = first_full & (first_char_buffer == EOT_CODE);
	wire logic mode_go     = eot_hold & end_of_state_latch & ~op_busy;
	// Start bit at stage one while both buffers are full
	wire logic ovf_cond    = first_full & second_full & ~shift_stage_one & serdes_delay_one
		& ~second_buf_load & ~second_reset_gate;

	// Power-on reset and mode change
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			power_on_reset <= 1'b1;
		end else begin
			power_on_reset <= por_cond;
		end
	end

	// Follows power-on reset or a finished end-of-transmission
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			mode_change <= 1'b1;
		end else begin
			mode_change <= power_on_reset | mode_go;
		end
	end

	// Mode triggers
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			mode_a <= trecv_pkg::MODE_A_RESET;
			mode_b <= trecv_pkg::MODE_B_RESET;
		end else if (power_on_reset || mode_go) begin
			mode_a <= trecv_pkg::MODE_A_RESET;
			mode_b <= trecv_pkg::MODE_B_RESET;
		end else begin
			if (set_mode_a_off) begin
				mode_a <= 1'b0;
			end
			if (set_mode_b_off) begin
				mode_b <= 1'b0;
			end
		end
	end

	// Pending end-of-transmission
	// Clear first: the buffer still holds the character during mode change
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			eot_hold <= 1'b0;
		end else if (mode_change) begin
			eot_hold <= 1'b0;
		end else if (eot_in_buf) begin
			eot_hold <= 1'b1;
		end
	end

	// First buffer
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			first_char_buffer <= trecv_pkg::BUF_RESET_VALUE;
			first_full        <= 1'b0;
		end else if (power_on_reset || mode_change) begin
			first_char_buffer <= trecv_pkg::BUF_RESET_VALUE;
			first_full        <= 1'b0;
		end else if (control_char_load) begin
			first_char_buffer <= control_char;
			first_full        <= 1'b1;
		end else if (first_buf_load) begin
			first_char_buffer <= first_buf_data;
			first_full        <= 1'b1;
		end else if (second_buf_load && !eot_in_buf) begin
			first_full <= 1'b0;
		end
	end

	// Second buffer
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			second_char_buffer <= trecv_pkg::BUF_RESET_VALUE;
			second_full        <= 1'b0;
		end else if (power_on_reset || mode_change || second_reset) begin
			second_char_buffer <= trecv_pkg::BUF_RESET_VALUE;
			second_full        <= 1'b0;
		end else if (second_buf_load && first_full) begin
			second_char_buffer <= first_char_buffer;
			second_full        <= 1'b1;
		end
	end

	// Overflow and second-buffer reset triggers
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			overflow_reset <= 1'b0;
		end else begin
			overflow_reset <= ovf_cond & ~overflow_reset;
		end
	end

	// Printer-cycle path and overflow path
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			second_reset <= 1'b0;
		end else if (power_on_reset) begin
			second_reset <= 1'b0;
		end else if (overflow_reset
			|| (second_full && !second_buf_load && !second_reset_gate && io_cycle)) begin
			second_reset <= 1'b1;
		end else if (control_clock) begin
			second_reset <= 1'b0;
		end
	end

	// Gate blocks repeated resets until the printer cycle ends
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			second_reset_gate <= 1'b0;
		end else if (power_on_reset) begin
			second_reset_gate <= 1'b0;
		end else if (overflow_reset || (second_reset && io_cycle)) begin
			second_reset_gate <= 1'b1;
		end else if (!io_cycle) begin
			second_reset_gate <= 1'b0;
		end
	end

	// One-second time-out after transmit entry
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			timer          <= '0;
			timer_run      <= 1'b0;
			time_out_latch <= 1'b0;
		end else if (power_on_reset || mode_b) begin
			timer          <= '0;
			timer_run      <= 1'b0;
			time_out_latch <= 1'b0;
		end else if (!time_out_latch) begin
			timer_run <= 1'b1;
			if (timer_run && timer == TIMER_W'(TIMEOUT_CYCLES - 1)) begin
				time_out_latch <= 1'b1;
			end else begin
				timer <= timer + 1'b1;
			end
		end
	end

	// Control character lock, held for end-of-transmission until mode change
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			lock_eot <= 1'b0;
		end else if (control_char_load && control_char == EOT_CODE) begin
			lock_eot <= 1'b1;
		end else if (mode_change) begin
			lock_eot <= 1'b0;
		end
	end

	// Keyboard lock
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			keyboard_lock <= 1'b1;
		end else begin
			keyboard_lock <= long_function
				| (comm_s
				& (~time_out_latch
				| control_char_load | lock_eot
				| ~sending
				| ~cts_s));
		end
	end

	// Motor
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			motor_run <= 1'b0;
		end else begin
			motor_run <= ~comm_s
				| ~mode_a | ~mode_b
				| initial_lowercase | io_cycle;
		end
	end

	// Initial lowercase
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			initial_lowercase <= 1'b0;
		end else if (!uc_s) begin
			initial_lowercase <= 1'b0;
		end else if (ctrl_recv && comm_s) begin
			initial_lowercase <= 1'b1;
		end
	end

	// Drives drop as soon as lowercase is seen
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			shift_trip_drive   <= 1'b0;
			shift_magnet_drive <= 1'b0;
		end else begin
			shift_trip_drive   <= initial_lowercase & uc_s;
			shift_magnet_drive <= initial_lowercase & uc_s;
		end
	end
endmodule : trecv_ctrl
`default_nettype wire

// ==== testbench/trecv_ctrl_props.sv ====
// Purpose: Port-level checks for the receive-end and interlock block
// Assumes: One clock, async active-high reset
// Notes:   Bound to the block from the testbench top file
`timescale 1ns/1ps
`default_nettype none
module trecv_ctrl_props (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic power_on_reset,
	input wire logic mode_change,
	input wire logic mode_a,
	input wire logic mode_b,
	input wire logic op_busy,
	input wire logic first_full,
	input wire logic second_full,
	input wire logic shift_stage_one,
	input wire logic serdes_delay_one,
	input wire logic second_buf_load,
	input wire logic overflow_reset,
	input wire logic second_reset,
	input wire logic second_reset_gate,
	input wire logic control_clock,
	input wire logic io_cycle,
	input wire logic long_function,
	input wire logic keyboard_lock,
	input wire logic motor_run,
	input wire logic initial_lowercase,
	input wire logic shift_trip_drive,
	input wire logic shift_magnet_drive
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);
	property p_ovf_cause;
		overflow_reset |-> $past(first_full && second_full && !shift_stage_one
			&& serdes_delay_one && !second_buf_load && !second_reset_gate);
	endproperty
	a_ovf_cause: assert property (p_ovf_cause) else $error("overflow without cause");
	property p_ovf_set;
		overflow_reset |=> second_reset && second_reset_gate;
	endproperty
	a_ovf_set: assert property (p_ovf_set) else $error("overflow did not reset");
	property p_rst_clr;
		second_reset && control_clock |=> !second_reset;
	endproperty
	a_rst_clr: assert property (p_rst_clr) else $error("reset trigger stuck");
	property p_gate_hold;
		second_reset_gate && io_cycle |=> second_reset_gate || power_on_reset || mode_change;
	endproperty
	a_gate_hold: assert property (p_gate_hold) else $error("gate dropped early");
	property p_mc_wait;
		mode_change && !$past(mode_change) && !$past(power_on_reset)
			|-> $past(!op_busy) || $past(!op_busy, 2);
	endproperty
	a_mc_wait: assert property (p_mc_wait) else $error("mode change while busy");
	property p_mc_modes;
		mode_change && !power_on_reset |-> mode_a && mode_b;
	endproperty
	a_mc_modes: assert property (p_mc_modes) else $error("mode change not ctrl-receive");
	property p_lock_long;
		long_function |=> keyboard_lock;
	endproperty
	a_lock_long: assert property (p_lock_long) else $error("lock missing");
	property p_motor_mode;
		(!mode_a || !mode_b) [*3] |-> motor_run;
	endproperty
	a_motor_mode: assert property (p_motor_mode) else $error("motor off in mode");
	property p_motor_il;
		(initial_lowercase || io_cycle) [*3] |-> motor_run;
	endproperty
	a_motor_il: assert property (p_motor_il) else $error("motor off in shift");
	property p_il_drive;
		initial_lowercase [*2] |-> shift_trip_drive && shift_magnet_drive;
	endproperty
	a_il_drive: assert property (p_il_drive) else $error("shift drive missing");
	c_ovf: cover property (overflow_reset);
	c_eot: cover property (mode_change && !power_on_reset);
	c_il: cover property (initial_lowercase);
endmodule : trecv_ctrl_props
`default_nettype wire

// ==== testbench/trecv_far_model.sv ====
// Purpose: Modem line and typewriter mechanism model
// Assumes: Levels change just after the falling clock edge
// Notes:   Mechanism powers up in uppercase
`timescale 1ns/1ps
`default_nettype none
module trecv_far_model (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic shift_trip_drive,
	input wire logic ready_up,
	input wire logic carrier_up,
	input wire logic cts_up,
	output var logic uppercase_contact,
	output var logic modem_ready,
	output var logic carrier_detect,
	output var logic clear_to_send
);
	logic [3:0] trip_cnt;
	// Slow shift-down under the trip magnet
	always_ff @(negedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			uppercase_contact <= 1'b1;
			trip_cnt <= 4'h0;
		end else if (shift_trip_drive) begin
			trip_cnt <= trip_cnt + 4'h1;
			if (&trip_cnt)
				uppercase_contact <= 1'b0;
		end
	end
	assign modem_ready = ready_up;
	assign carrier_detect = carrier_up;
	assign clear_to_send = ready_up & cts_up;
endmodule : trecv_far_model
`default_nettype wire

// ==== testbench/test_trecv_ctrl.sv ====
// Purpose: Self-checking bench for the receive-end and interlock block
// Assumes: Inputs driven at falling edge; short time-out of 20 cycles
// Notes:   Pin inputs come through a three-flop synchroniser
`timescale 1ns/1ps
`default_nettype none
module test_trecv_ctrl;
	logic clk, sys_rst, dc_power_ok, supply_relay, dialup_fitted, communicate;
	logic io_cycle, long_function, end_of_state_latch, op_busy, control_clock;
	logic first_buf_load, second_buf_load, shift_stage_one, serdes_delay_one;
	logic control_char_load, set_mode_a_off, set_mode_b_off, ready_up, carrier_up, cts_up;
	logic [6:0] first_buf_data, control_char, first_char_buffer, second_char_buffer;
	logic modem_ready, carrier_detect, clear_to_send, uppercase_contact;
	logic power_on_reset, mode_change, mode_a, mode_b, first_full, second_full;
	logic overflow_reset, second_reset, second_reset_gate, motor_run, keyboard_lock;
	logic time_out_latch, initial_lowercase, shift_trip_drive, shift_magnet_drive;
	int num_errors, checked;
	trecv_ctrl #(.TIMEOUT_CYCLES(20)) i_trecv_ctrl (.*);
	trecv_far_model i_trecv_far_model (.*);
	always #50 clk = ~clk;
	task close_out;
		if (num_errors == 0 && checked > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : close_out
	task chk(input logic [6:0] got, input logic [6:0] exp);
		checked++;
		if (got !== exp) begin
			num_errors++;
			$display("MISMATCH %0t got %h want %h", $time, got, exp);
		end
	endtask : chk
	task automatic await(ref logic s, input logic v);
		int n;
		n = 0;
		while (s !== v && n < 200) begin
			@(negedge clk);
			n++;
		end
		if (n >= 200)
			chk(s, v);
	endtask : await
	task automatic pulse(ref logic s);
		s = 1'b1;
		@(negedge clk);
		s = 1'b0;
	endtask : pulse
	initial begin
		#500000;
		num_errors++;
		$display("MISMATCH %0t watchdog expired", $time);
		close_out();
	end
	initial begin
		{clk, dc_power_ok, supply_relay, dialup_fitted, io_cycle, long_function} = '0;
		{end_of_state_latch, op_busy, control_clock, first_buf_load} = '0;
		{second_buf_load, serdes_delay_one, control_char_load} = '0;
		{set_mode_a_off, set_mode_b_off, first_buf_data, control_char} = '0;
		{sys_rst, shift_stage_one, ready_up, carrier_up, communicate, cts_up} = '1;
		num_errors = 0;
		checked = 0;
		dc_power_ok = 1'b1;
		repeat (8) @(negedge clk);
		sys_rst = 1'b0;
		repeat (10) @(negedge clk);
		chk(power_on_reset, 1'b1);
		supply_relay = 1'b1;
		await(power_on_reset, 1'b0);
		chk(power_on_reset, 1'b0);
		await(mode_change, 1'b0);
		chk({mode_a, mode_b}, 7'h03);
		await(initial_lowercase, 1'b1);
		chk({shift_trip_drive, shift_magnet_drive, motor_run}, 7'h07);
		await(initial_lowercase, 1'b0);
		chk(initial_lowercase, 1'b0);
		repeat (3) @(negedge clk);
		chk({motor_run, keyboard_lock}, 7'h01);
		pulse(set_mode_b_off);
		repeat (12) @(negedge clk);
		chk({time_out_latch, keyboard_lock, motor_run}, 7'h03);
		repeat (18) @(negedge clk);
		chk({time_out_latch, keyboard_lock}, 7'h02);
		cts_up = 1'b0;
		repeat (6) @(negedge clk);
		chk(keyboard_lock, 1'b1);
		cts_up = 1'b1;
		repeat (6) @(negedge clk);
		chk(keyboard_lock, 1'b0);
		{op_busy, end_of_state_latch} = 2'b11;
		control_char = 7'h1f;
		pulse(control_char_load);
		chk(keyboard_lock, 1'b1);
		repeat (5) @(negedge clk);
		chk({mode_change, first_full, keyboard_lock}, 7'h03);
		op_busy = 1'b0;
		await(mode_change, 1'b1);
		chk({mode_change, mode_a, mode_b}, 7'h07);
		repeat (2) @(negedge clk);
		chk(first_full, 1'b0);
		chk(first_char_buffer, trecv_pkg::BUF_RESET_VALUE);
		end_of_state_latch = 1'b0;
		first_buf_data = 7'h41;
		pulse(first_buf_load);
		pulse(second_buf_load);
		pulse(first_buf_load);
		chk({first_full, second_full}, 7'h03);
		chk(second_char_buffer, 7'h41);
		{serdes_delay_one, shift_stage_one} = 2'b10;
		@(negedge clk);
		{serdes_delay_one, shift_stage_one} = 2'b01;
		chk(overflow_reset, 1'b1);
		@(negedge clk);
		io_cycle = 1'b1;
		chk({second_reset, second_reset_gate}, 7'h03);
		@(negedge clk);
		chk(second_full, 1'b0);
		chk(second_char_buffer, trecv_pkg::BUF_RESET_VALUE);
		pulse(control_clock);
		@(negedge clk);
		chk({second_reset, second_reset_gate}, 7'h01);
		io_cycle = 1'b0;
		repeat (3) @(negedge clk);
		chk(second_reset_gate, 1'b0);
		communicate = 1'b0;
		repeat (6) @(negedge clk);
		chk({motor_run, keyboard_lock}, 7'h02);
		long_function = 1'b1;
		repeat (2) @(negedge clk);
		chk(keyboard_lock, 1'b1);
		{long_function, communicate} = 2'b01;
		for (int i = 0; i < 2; i++) begin
			dialup_fitted = i[0];
			if (i == 1)
				carrier_up = 1'b0;
			else
				ready_up = 1'b0;
			await(power_on_reset, 1'b1);
			chk(power_on_reset, 1'b1);
			{ready_up, carrier_up} = 2'b11;
			await(power_on_reset, 1'b0);
			await(mode_change, 1'b0);
		end
		close_out();
	end
endmodule : test_trecv_ctrl
bind trecv_ctrl trecv_ctrl_props i_trecv_ctrl_props (.*);
`default_nettype wire
